// ===== hw/pio_pkg.sv
package pio_pkg;

  localparam int unsigned PORT_W       = 8;
  localparam int unsigned SERIAL_ALT_W = 6;
  localparam int unsigned ANALOG_CH0   = 2;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_HIGH_DIR = 6'h02;
  localparam logic [5:0] IDX_LOW_DIR  = 6'h03;
  localparam logic [5:0] IDX_HIGH_VAL = 6'h04;
  localparam logic [5:0] IDX_LOW_VAL  = 6'h05;
  localparam logic [5:0] IDX_DBUS_VAL = 6'h06;
  localparam logic [5:0] IDX_DBUS_DIR = 6'h07;
  localparam logic [5:0] IDX_SER_VAL  = 6'h08;
  localparam logic [5:0] IDX_SER_DIR  = 6'h09;
  localparam logic [5:0] IDX_ANA_VAL  = 6'h0A;
  localparam logic [5:0] IDX_PULL     = 6'h0B;
  localparam logic [5:0] IDX_STATUS   = 6'h0C;

  localparam logic [7:0] DIR_RESET  = 8'h00;
  localparam logic [7:0] PULL_RESET = 8'h00;

  localparam int unsigned PULL_HIGH_BIT  = 0;
  localparam int unsigned PULL_LOW_BIT   = 1;
  localparam int unsigned STAT_EXP_BIT   = 0;
  localparam int unsigned STAT_ALT_LSB   = 2;

  typedef logic [PORT_W-1:0] pio_byte_t;

endpackage

// ===== hw/pio_port_if.sv
interface pio_port_if #(
  parameter int unsigned W = 8
);
  logic [W-1:0] latch;
  logic [W-1:0] dir;
  logic [W-1:0] alt_en;
  logic [W-1:0] alt_out;
  logic [W-1:0] alt_oe;
  logic [W-1:0] pin_sync;
  logic [W-1:0] pin_out;
  logic [W-1:0] pin_oe;
  logic [W-1:0] rd_val;

  modport ctrl (
    output latch, dir, alt_en, alt_out, alt_oe, pin_sync,
    input  pin_out, pin_oe, rd_val
  );

  modport port (
    input  latch, dir, alt_en, alt_out, alt_oe, pin_sync,
    output pin_out, pin_oe, rd_val
  );
endinterface

// ===== hw/pio_sync.sv
module pio_sync #(
  parameter int unsigned W = 8
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_reg;

  initial begin
    if (W < 1) $error("pio_sync: width must be at least 1");
  end

  // First stage feeds only the second stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= '0;
      q_o      <= '0;
    end else begin
      meta_reg <= d_i;
      q_o      <= meta_reg;
    end
  end
endmodule

// ===== hw/pio_port.sv
module pio_port #(
  parameter int unsigned W = 8
) (
  pio_port_if.port pif
);
  initial begin
    if (W < 1) $error("pio_port: width must be at least 1");
  end

  // One slice per pin
  for (genvar i = 0; i < W; i++) begin : g_pin
    assign pif.pin_oe[i]  = pif.alt_en[i] ? pif.alt_oe[i] : pif.dir[i];
    assign pif.pin_out[i] = pif.alt_en[i] ? pif.alt_out[i] : pif.latch[i];
    // Output pins read back the latch, inputs read the pin
    assign pif.rd_val[i]  = pif.dir[i] ? pif.latch[i] : pif.pin_sync[i];
  end
endmodule

// ===== hw/pio_gpio.sv
// What this block does
// - Direction bit 1 drives the pin as output, 0 leaves it an input.
// - High-address port is eight bidirectional pins with value and direction registers.
// - Expanded or test: high-address pins drive address 8..15, its registers leave map.
// - Single-chip or bootstrap: high-address pins reset to inputs, pull-ups selectable.
// - Value latches at 0x04, 0x06, 0x05 read and write in single-chip or bootstrap, survive reset.
// - High-address direction at 0x02 clears to zero on reset.
// - Low-address direction at 0x03 clears to zero on reset.
// - Expanded or test: data-bus pins carry data bits, registers leave map.
// - Single-chip or bootstrap: data-bus pins reset to high-impedance inputs.
// - Serial pins 0..5 serve receive, transmit, MISO, MOSI, SCK and SS.
// - Serial pins reset to general-purpose high-impedance inputs.
// - Serial latch at 0x08 stays writable; alternate pins ignore latch writes.
// - Analog port is input-only; its value at 0x0A is read-only, no reset; the code reads it through pio_sync, which reset clears to zero.
// - Analog pin n feeds converter channel n+2; the code drives pin n onto analog_chan_o bit n, with no offset.
// - Analog pins reset to general-purpose high-impedance inputs.
// - Expanded or test: low-address pins drive address 0..7, registers leave map.
// - Single-chip or bootstrap: low-address pins reset to inputs, pull-ups selectable.
module pio_gpio
  import pio_pkg::*;
#(
  parameter int unsigned ADR_W = 8
) (
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [ADR_W-1:0]        wb_adr_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic [31:0]             wb_dat_i,
  output logic      [31:0]             wb_dat_o,
  output logic                         wb_ack_o,
  input  wire logic                    mode_expanded_i,
  input  wire logic [15:0]             ext_addr_i,
  input  wire pio_pkg::pio_byte_t      ext_data_i,
  input  wire logic                    ext_data_oe_i,
  output pio_pkg::pio_byte_t           ext_data_o,
  output logic                         ext_cycle_o,
  input  wire logic [pio_pkg::SERIAL_ALT_W-1:0] serial_alt_en_i,
  input  wire logic [pio_pkg::SERIAL_ALT_W-1:0] serial_alt_out_i,
  input  wire logic [pio_pkg::SERIAL_ALT_W-1:0] serial_alt_oe_i,
  output pio_pkg::pio_byte_t           serial_pin_val_o,
  input  wire pio_pkg::pio_byte_t      high_addr_pin_i,
  output pio_pkg::pio_byte_t           high_addr_pin_o,
  output pio_pkg::pio_byte_t           high_addr_pin_oe_o,
  input  wire pio_pkg::pio_byte_t      data_bus_pin_i,
  output pio_pkg::pio_byte_t           data_bus_pin_o,
  output pio_pkg::pio_byte_t           data_bus_pin_oe_o,
  input  wire pio_pkg::pio_byte_t      serial_pin_i,
  output pio_pkg::pio_byte_t           serial_pin_o,
  output pio_pkg::pio_byte_t           serial_pin_oe_o,
  input  wire pio_pkg::pio_byte_t      low_addr_pin_i,
  output pio_pkg::pio_byte_t           low_addr_pin_o,
  output pio_pkg::pio_byte_t           low_addr_pin_oe_o,
  input  wire pio_pkg::pio_byte_t      analog_pin_i,
  output pio_pkg::pio_byte_t           analog_chan_o,
  output logic                         analog_read_o,
  output logic                         high_addr_pullup_en_o,
  output logic                         low_addr_pullup_en_o
);
  import pio_pkg::*;

  initial begin
    if (ADR_W < 8) $error("pio_gpio: address must be at least 8 bits");
  end

  // ==========================================================
  // Pin synchronisers
  // ==========================================================
  pio_byte_t hi_sync;
  pio_byte_t db_sync;
  pio_byte_t ser_sync;
  pio_byte_t lo_sync;
  pio_byte_t ana_sync;

  pio_sync #(
    .W (5 * PORT_W)
  ) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({analog_pin_i, low_addr_pin_i, serial_pin_i, data_bus_pin_i, high_addr_pin_i}),
    .q_o   ({ana_sync, lo_sync, ser_sync, db_sync, hi_sync})
  );

  // ==========================================================
  // Bus decode
  // ==========================================================
  logic [5:0] idx;
  logic       req;
  logic       removed;
  logic       commit;
  logic       ack_reg;

  assign idx = wb_adr_i[7:2];
  assign req = wb_cyc_i & wb_stb_i;

  always_comb begin
    removed = 1'b0;
    if (mode_expanded_i) begin
      unique case (idx)
        IDX_HIGH_DIR, IDX_HIGH_VAL, IDX_LOW_DIR, IDX_LOW_VAL,
        IDX_DBUS_DIR, IDX_DBUS_VAL: removed = 1'b1;
        default:                    removed = 1'b0;
      endcase
    end
  end

  // Writes land on the edge where the master samples ack
  // Removed offsets not written
  assign commit = ack_reg & req & wb_we_i & wb_sel_i[0] & ~removed;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req & ~ack_reg;
    end
  end

  assign wb_ack_o = ack_reg;

  // ==========================================================
  // Direction and pull-up registers
  // ==========================================================
  pio_byte_t hi_dir_reg;
  pio_byte_t lo_dir_reg;
  pio_byte_t db_dir_reg;
  pio_byte_t ser_dir_reg;
  pio_byte_t pull_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hi_dir_reg <= DIR_RESET;
    end else if (commit && idx == IDX_HIGH_DIR) begin
      hi_dir_reg <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lo_dir_reg <= DIR_RESET;
    end else if (commit && idx == IDX_LOW_DIR) begin
      lo_dir_reg <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      db_dir_reg <= DIR_RESET;
    end else if (commit && idx == IDX_DBUS_DIR) begin
      db_dir_reg <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ser_dir_reg <= DIR_RESET;
    end else if (commit && idx == IDX_SER_DIR) begin
      ser_dir_reg <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pull_reg <= PULL_RESET;
    end else if (commit && idx == IDX_PULL) begin
      pull_reg <= wb_dat_i[7:0];
    end
  end

  assign high_addr_pullup_en_o = pull_reg[PULL_HIGH_BIT] & ~mode_expanded_i;
  assign low_addr_pullup_en_o  = pull_reg[PULL_LOW_BIT] & ~mode_expanded_i;

  // ==========================================================
  // Value latches, deliberately without reset
  // ==========================================================
  pio_byte_t hi_val_reg;
  pio_byte_t lo_val_reg;
  pio_byte_t db_val_reg;
  pio_byte_t ser_val_reg;

  always_ff @(posedge clk_i) begin
    if (commit && idx == IDX_HIGH_VAL) begin
      hi_val_reg <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (commit && idx == IDX_LOW_VAL) begin
      lo_val_reg <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (commit && idx == IDX_DBUS_VAL) begin
      db_val_reg <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (commit && idx == IDX_SER_VAL) begin
      ser_val_reg <= wb_dat_i[7:0];
    end
  end

  // ==========================================================
  // Port slices
  // ==========================================================
  pio_port_if #(.W(PORT_W)) hi_if ();
  pio_port_if #(.W(PORT_W)) db_if ();
  pio_port_if #(.W(PORT_W)) ser_if ();
  pio_port_if #(.W(PORT_W)) lo_if ();

  assign hi_if.latch    = hi_val_reg;
  assign hi_if.dir      = hi_dir_reg;
  assign hi_if.pin_sync = hi_sync;
  assign hi_if.alt_en   = {PORT_W{mode_expanded_i}};
  assign hi_if.alt_out  = ext_addr_i[15:8];
  assign hi_if.alt_oe   = {PORT_W{1'b1}};

  assign lo_if.latch    = lo_val_reg;
  assign lo_if.dir      = lo_dir_reg;
  assign lo_if.pin_sync = lo_sync;
  assign lo_if.alt_en   = {PORT_W{mode_expanded_i}};
  assign lo_if.alt_out  = ext_addr_i[7:0];
  assign lo_if.alt_oe   = {PORT_W{1'b1}};

  assign db_if.latch    = db_val_reg;
  assign db_if.dir      = db_dir_reg;
  assign db_if.pin_sync = db_sync;
  assign db_if.alt_en   = {PORT_W{mode_expanded_i}};
  assign db_if.alt_out  = ext_data_i;
  assign db_if.alt_oe   = {PORT_W{ext_data_oe_i}};

  assign ser_if.latch    = ser_val_reg;
  assign ser_if.dir      = ser_dir_reg;
  assign ser_if.pin_sync = ser_sync;
  assign ser_if.alt_en   = {{(PORT_W - SERIAL_ALT_W){1'b0}}, serial_alt_en_i};
  assign ser_if.alt_out  = {{(PORT_W - SERIAL_ALT_W){1'b0}}, serial_alt_out_i};
  assign ser_if.alt_oe   = {{(PORT_W - SERIAL_ALT_W){1'b0}}, serial_alt_oe_i};

  pio_port #(.W(PORT_W)) u_hi  (.pif (hi_if.port));
  pio_port #(.W(PORT_W)) u_db  (.pif (db_if.port));
  pio_port #(.W(PORT_W)) u_ser (.pif (ser_if.port));
  pio_port #(.W(PORT_W)) u_lo  (.pif (lo_if.port));

  assign high_addr_pin_o    = hi_if.pin_out;
  assign high_addr_pin_oe_o = hi_if.pin_oe;
  assign low_addr_pin_o     = lo_if.pin_out;
  assign low_addr_pin_oe_o  = lo_if.pin_oe;
  assign data_bus_pin_o     = db_if.pin_out;
  assign data_bus_pin_oe_o  = db_if.pin_oe;
  assign serial_pin_o       = ser_if.pin_out;
  assign serial_pin_oe_o    = ser_if.pin_oe;

  assign ext_data_o       = db_sync;
  assign serial_pin_val_o = ser_sync;

  assign analog_chan_o = ana_sync;

  // ==========================================================
  // Read data and side pulses
  // ==========================================================
  pio_byte_t rd_mux;
  pio_byte_t status;
  logic      rd_take;

  always_comb begin
    status = '0;
    status[STAT_EXP_BIT] = mode_expanded_i;
    status[STAT_ALT_LSB +: SERIAL_ALT_W] = serial_alt_en_i;
  end

  always_comb begin
    rd_mux = '0;
    if (removed) begin
      // External cycle answers with what the data-bus pins show
      rd_mux = db_sync;
    end else begin
      unique case (idx)
        IDX_HIGH_DIR: rd_mux = hi_dir_reg;
        IDX_LOW_DIR:  rd_mux = lo_dir_reg;
        IDX_HIGH_VAL: rd_mux = hi_if.rd_val;
        IDX_LOW_VAL:  rd_mux = lo_if.rd_val;
        IDX_DBUS_VAL: rd_mux = db_if.rd_val;
        IDX_DBUS_DIR: rd_mux = db_dir_reg;
        IDX_SER_VAL:  rd_mux = ser_if.rd_val;
        IDX_SER_DIR:  rd_mux = ser_dir_reg;
        IDX_ANA_VAL:  rd_mux = ana_sync;
        IDX_PULL:     rd_mux = pull_reg;
        IDX_STATUS:   rd_mux = status;
        default:      rd_mux = '0;
      endcase
    end
  end

  assign rd_take = req & ~ack_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (rd_take) begin
      wb_dat_o <= {24'h00_0000, rd_mux};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      analog_read_o <= 1'b0;
    end else begin
      analog_read_o <= rd_take & ~wb_we_i & (idx == IDX_ANA_VAL);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_cycle_o <= 1'b0;
    end else begin
      ext_cycle_o <= rd_take & removed;
    end
  end
endmodule

// ===== dv/pio_checker.sv
// ====
// Port relations of the parallel I/O block
module pio_checker
  import pio_pkg::*;
#(
  parameter int unsigned ADR_W = 8
) (
  input wire logic                 clk_i,
  input wire logic                 rst_i,
  input wire logic                 wb_cyc_i,
  input wire logic                 wb_stb_i,
  input wire logic                 wb_we_i,
  input wire logic [ADR_W-1:0]     wb_adr_i,
  input wire logic                 wb_ack_o,
  input wire logic                 mode_expanded_i,
  input wire logic [15:0]          ext_addr_i,
  input wire pio_pkg::pio_byte_t   ext_data_i,
  input wire logic                 ext_data_oe_i,
  input wire logic                 ext_cycle_o,
  input wire logic [5:0]           serial_alt_en_i,
  input wire logic [5:0]           serial_alt_out_i,
  input wire logic [5:0]           serial_alt_oe_i,
  input wire pio_pkg::pio_byte_t   serial_pin_o,
  input wire pio_pkg::pio_byte_t   serial_pin_oe_o,
  input wire pio_pkg::pio_byte_t   high_addr_pin_o,
  input wire pio_pkg::pio_byte_t   high_addr_pin_oe_o,
  input wire pio_pkg::pio_byte_t   data_bus_pin_o,
  input wire pio_pkg::pio_byte_t   data_bus_pin_oe_o,
  input wire pio_pkg::pio_byte_t   low_addr_pin_o,
  input wire pio_pkg::pio_byte_t   low_addr_pin_oe_o,
  input wire pio_pkg::pio_byte_t   analog_pin_i,
  input wire pio_pkg::pio_byte_t   analog_chan_o,
  input wire logic                 analog_read_o,
  input wire logic                 high_addr_pullup_en_o,
  input wire logic                 low_addr_pullup_en_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic       rm_reg;
  logic [5:0] idx;
  assign idx = wb_adr_i[7:2];
  // Removed offsets in expanded mode, taken at the request edge
  always_ff @(posedge clk_i) rm_reg <= mode_expanded_i && idx >= IDX_HIGH_DIR && idx <= IDX_DBUS_DIR;
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_pulse; wb_ack_o ##1 !wb_ack_o; endsequence
  // ====
  // Assertions
  AST_ACK_PULSE: assert property (s_req |=> s_pulse)
    else $error("ack is not a single pulse");
  AST_EXT_CYCLE: assert property (s_req |=> ext_cycle_o == rm_reg)
    else $error("external cycle pulse wrong");
  AST_ANA_READ: assert property (s_req ##0 (!wb_we_i && idx == IDX_ANA_VAL) |=> analog_read_o)
    else $error("analog read pulse missing");
  AST_HIGH_EXP: assert property (mode_expanded_i |-> high_addr_pin_o == ext_addr_i[15:8]
    && high_addr_pin_oe_o == 8'hFF)
    else $error("high address pins wrong");
  AST_LOW_EXP: assert property (mode_expanded_i |-> low_addr_pin_o == ext_addr_i[7:0]
    && low_addr_pin_oe_o == 8'hFF)
    else $error("low address pins wrong");
  AST_DBUS_EXP: assert property (mode_expanded_i |-> data_bus_pin_o == ext_data_i
    && data_bus_pin_oe_o == {8{ext_data_oe_i}})
    else $error("data bus pins wrong");
  AST_SER_ALT: assert property (((serial_pin_o[5:0] ^ serial_alt_out_i) & serial_alt_en_i) == 6'h00
    && ((serial_pin_oe_o[5:0] ^ serial_alt_oe_i) & serial_alt_en_i) == 6'h00)
    else $error("serial alternate pin wrong");
  AST_RST_INPUT: assert property ($fell(rst_i) && !mode_expanded_i |-> (high_addr_pin_oe_o
    | low_addr_pin_oe_o | data_bus_pin_oe_o | (serial_pin_oe_o & ~{2'h0, serial_alt_en_i})) == 8'h00)
    else $error("pins not inputs after reset");
  AST_ANA_SYNC: assert property (!$past(rst_i) && !$past(rst_i, 2)
    |-> analog_chan_o == $past(analog_pin_i, 2))
    else $error("analog channel mismatch");
  AST_PULL_EXP: assert property (mode_expanded_i |-> !high_addr_pullup_en_o && !low_addr_pullup_en_o)
    else $error("pull-up on in expanded mode");
endmodule

bind pio_gpio pio_checker #(.ADR_W(ADR_W)) chk_u (.*);

// ===== dv/pio_pin_model.sv
// ====
// Outside device on one port's pins
module pio_pin_model
  import pio_pkg::*;
(
  input  wire pio_pkg::pio_byte_t drv_i,
  input  wire pio_pkg::pio_byte_t out_i,
  input  wire pio_pkg::pio_byte_t oe_i,
  output pio_pkg::pio_byte_t      pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  assign pin_o = (out_i & oe_i) | (drv_i & ~oe_i);
endmodule

// ===== dv/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pio_pkg::*;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic        mode_expanded_i, ext_data_oe_i, ext_cycle_o, analog_read_o;
  logic        high_addr_pullup_en_o, low_addr_pullup_en_o;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [15:0] ext_addr_i;
  logic [5:0]  serial_alt_en_i, serial_alt_out_i, serial_alt_oe_i;
  pio_byte_t   ext_data_i, ext_data_o, serial_pin_val_o, analog_pin_i, analog_chan_o;
  pio_byte_t   high_addr_pin_i, high_addr_pin_o, high_addr_pin_oe_o;
  pio_byte_t   data_bus_pin_i, data_bus_pin_o, data_bus_pin_oe_o;
  pio_byte_t   serial_pin_i, serial_pin_o, serial_pin_oe_o;
  pio_byte_t   low_addr_pin_i, low_addr_pin_o, low_addr_pin_oe_o;
  pio_byte_t   drv [4];
  int          mismatches, checked, seed;
  logic [31:0] expq [$];
  localparam logic [5:0] DIR_IX [4] = '{IDX_HIGH_DIR, IDX_LOW_DIR, IDX_DBUS_DIR, IDX_SER_DIR};
  localparam logic [5:0] VAL_IX [4] = '{IDX_HIGH_VAL, IDX_LOW_VAL, IDX_DBUS_VAL, IDX_SER_VAL};

  pio_gpio dut_u (.*);
  pio_pin_model hi_m (.drv_i(drv[0]), .out_i(high_addr_pin_o), .oe_i(high_addr_pin_oe_o), .pin_o(high_addr_pin_i));
  pio_pin_model lo_m (.drv_i(drv[1]), .out_i(low_addr_pin_o), .oe_i(low_addr_pin_oe_o), .pin_o(low_addr_pin_i));
  pio_pin_model db_m (.drv_i(drv[2]), .out_i(data_bus_pin_o), .oe_i(data_bus_pin_oe_o), .pin_o(data_bus_pin_i));
  pio_pin_model sr_m (.drv_i(drv[3]), .out_i(serial_pin_o), .oe_i(serial_pin_oe_o), .pin_o(serial_pin_i));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // ====
  // Checking and bus tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    // A read still waiting for its answer counts against the run
    if (expq.size() != 0) mismatches++;
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic wb(input logic w, input logic [5:0] idx, input logic [7:0] d, input logic [3:0] s = 4'hF);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_sel_i <= s;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= {24'h0, d};
    for (int n = 0; n < 20; n++) begin
      @(posedge clk_i);
      if (wb_ack_o === 1'b1) break;
      if (n == 19) begin
        mismatches++;
        end_of_test();
      end
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    wb(1'b1, idx, d);
  endtask

  task automatic rd(input logic [5:0] idx, input logic [7:0] exp);
    expq.push_back({24'h0, exp});
    wb(1'b0, idx, 8'h00);
  endtask

  function automatic logic [15:0] pins(input int k);
    case (k)
      0: return {high_addr_pin_oe_o, high_addr_pin_o};
      1: return {low_addr_pin_oe_o, low_addr_pin_o};
      2: return {data_bus_pin_oe_o, data_bus_pin_o};
      default: return {serial_pin_oe_o, serial_pin_o};
    endcase
  endfunction

  // Read data is judged against the oldest note taken when the read was issued
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      // An answer with no note is an unexpected read
      if (expq.size() == 0) chk(32'h0000_0000, 32'hFFFF_FFFF);
      else chk(wb_dat_o, expq.pop_front());
    end
  end

  // ====
  // Main sequence
  initial begin
    logic [7:0] r;
    seed = 32'hFC82;
    rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, mode_expanded_i, ext_data_oe_i} = 5'h00;
    {wb_adr_i, wb_dat_i, ext_addr_i, ext_data_i, analog_pin_i} = 72'h0;
    {serial_alt_en_i, serial_alt_out_i, serial_alt_oe_i} = 18'h0;
    wb_sel_i = 4'hF;
    drv = '{default: 8'h00};
    mismatches = 0;
    checked = 0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(IDX_HIGH_DIR, DIR_RESET);
    rd(IDX_LOW_DIR, DIR_RESET);
    chk({high_addr_pin_oe_o, data_bus_pin_oe_o, serial_pin_oe_o, low_addr_pin_oe_o}, 32'h0);
    for (int k = 0; k < 4; k++) begin
      r = 8'($random(seed));
      wr(DIR_IX[k], 8'hFF);
      wr(VAL_IX[k], r);
      rd(VAL_IX[k], r);
      chk(pins(k), {8'hFF, r});
      r = 8'($random(seed));
      drv[k] <= r;
      wr(DIR_IX[k], 8'h00);
      repeat (4) @(posedge clk_i);
      rd(VAL_IX[k], r);
      if (k == 3) chk(serial_pin_val_o, r);
      chk(pins(k) & 16'hFF00, 32'h0);
    end
    wr(IDX_HIGH_DIR, 8'hFF);
    wr(IDX_HIGH_VAL, 8'hA5);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(IDX_HIGH_DIR, DIR_RESET);
    wr(IDX_HIGH_DIR, 8'hFF);
    rd(IDX_HIGH_VAL, 8'hA5);
    // A write without the low byte lane selected is dropped
    wb(1'b1, IDX_HIGH_VAL, 8'h00, 4'hE);
    rd(IDX_HIGH_VAL, 8'hA5);
    wr(IDX_SER_DIR, 8'hFF);
    serial_alt_en_i <= 6'h3F;
    serial_alt_out_i <= 6'($random(seed));
    serial_alt_oe_i <= 6'($random(seed));
    r = 8'($random(seed));
    wr(IDX_SER_VAL, r);
    rd(IDX_SER_VAL, r);
    rd(IDX_STATUS, 8'hFC);
    chk(serial_pin_o[7:6], r[7:6]);
    serial_alt_en_i <= 6'h00;
    r = 8'($random(seed));
    analog_pin_i <= r;
    repeat (4) @(posedge clk_i);
    chk(analog_chan_o, r);
    // No conversion runs here, so the analog value may be read
    rd(IDX_ANA_VAL, r);
    wr(IDX_ANA_VAL, ~r);
    rd(IDX_ANA_VAL, r);
    rd(6'h20, 8'h00);
    wr(IDX_PULL, 8'h03);
    @(posedge clk_i);
    chk({high_addr_pullup_en_o, low_addr_pullup_en_o}, 2'b11);
    wr(IDX_HIGH_VAL, 8'h3C);
    mode_expanded_i <= 1'b1;
    ext_addr_i <= 16'($random(seed));
    drv[2] <= 8'h96;
    repeat (4) @(posedge clk_i);
    chk({high_addr_pullup_en_o, low_addr_pullup_en_o}, 2'b00);
    chk({high_addr_pin_o, low_addr_pin_o}, ext_addr_i);
    chk(ext_data_o, 8'h96);
    for (int i = 2; i < 8; i++) rd(6'(i), 8'h96);
    rd(IDX_STATUS, 8'h01);
    wr(IDX_HIGH_VAL, 8'hC3);
    ext_data_i <= 8'h5A;
    ext_data_oe_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk(pins(2), 16'hFF5A);
    mode_expanded_i <= 1'b0;
    ext_data_oe_i <= 1'b0;
    rd(IDX_HIGH_VAL, 8'h3C);
    repeat (2) @(posedge clk_i);
    end_of_test();
  end
endmodule
